// ---- inc/tlc_pkg.sv ----
/*
  Shared constants and types for the trail trace lock and compare block.
  Assumes one memory group per instance, A and B drop sides.
*/
package tlc_pkg;

  localparam int MSG_BYTES = 16;
  localparam int POS_W = 4;
  localparam int ALIGN_BIT = 7;

  localparam logic [7:0] ACC_A_BASE = 8'h40;
  localparam logic [7:0] EXP_A_BASE = 8'h50;
  localparam logic [7:0] ACC_B_BASE = 8'hC0;
  localparam logic [7:0] EXP_B_BASE = 8'hD0;

  localparam logic [POS_W-1:0] POS_FIRST = 4'h0;
  localparam logic [POS_W-1:0] POS_NEXT = 4'h1;
  localparam logic [POS_W-1:0] POS_LAST = 4'hF;

  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] REPEATS_TO_LOCK = 2'h3;
  localparam logic [1:0] CHANGES_TO_UNLOCK = 2'h3;

  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef logic [MSG_BYTES-1:0][7:0] tlc_msg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_REPEAT,
    ST_LOCKED
  } tlc_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tlc_trace_s;

  typedef struct packed {
    logic compare_enable;
    logic length_select;
  } tlc_mode_s;

  typedef struct packed {
    logic rdi_enable;
    logic ais_enable;
  } tlc_conseq_s;

  typedef struct packed {
    logic lock_lost;
    logic mismatch;
    logic send_rdi;
    logic send_ais;
  } tlc_alarm_s;

endpackage : tlc_pkg

// ---- rtl/tlc_align_chk.sv ----
/*
  Alignment bit check for one incoming trace byte at a message position.
  Assumes the byte and position come from logic on the same clock.
*/
`timescale 1ns/100ps
module tlc_align_chk (
  input wire logic [7:0] data,
  input wire logic [tlc_pkg::POS_W-1:0] pos,
  output logic is_start,
  output logic fits
);

  logic first;

  // only the msb is framing; the low seven bits are payload
  assign is_start = data[tlc_pkg::ALIGN_BIT];
  assign first = (pos == tlc_pkg::POS_FIRST);
  assign fits = (is_start == first);

endmodule : tlc_align_chk

// ---- rtl/tlc_msg_cmp.sv ----
/*
  Whole-message comparator: flags any differing byte of two 16-byte stores.
  Assumes both stores are registered by the caller.
*/
`timescale 1ns/100ps
module tlc_msg_cmp #(
  parameter int BYTES = tlc_pkg::MSG_BYTES
) (
  input wire tlc_pkg::tlc_msg_t left_msg,
  input wire tlc_pkg::tlc_msg_t right_msg,
  output logic differ
);

  logic [BYTES-1:0] byte_diff;

  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      assign byte_diff[i] = (left_msg[i] != right_msg[i]);
    end
  endgenerate

  assign differ = |byte_diff;

endmodule : tlc_msg_cmp

// ---- rtl/tlc_top.sv ----
/*
  Trail trace lock and compare for one port, A and B drop sides.
  Assumes trace bytes arrive from drop logic on CLK_SYS, one valid per byte,
  and that the processor port is synchronous to CLK_SYS.
  more than two sides would share the B pages; the map has only two.
*/
`timescale 1ns/100ps
module tlc_top #(
  parameter int SIDES = 2
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire tlc_pkg::tlc_trace_s [SIDES-1:0] TRACE_IN,
  input wire tlc_pkg::tlc_mode_s [SIDES-1:0] TRACE_MODE,
  input wire tlc_pkg::tlc_conseq_s [SIDES-1:0] CONSEQ_ENABLE,
  input wire logic [7:0] CPU_ADDR,
  input wire logic CPU_WR,
  input wire logic CPU_RD,
  input wire logic [7:0] CPU_WDATA,
  output logic [7:0] CPU_RDATA,
  output tlc_pkg::tlc_alarm_s [SIDES-1:0] ALARM_OUT
);

  logic [SIDES-1:0][7:0] side_rdata;
  logic [SIDES-1:0] side_hit;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] rd_or;

  genvar s;
  generate
    for (s = 0; s < SIDES; s++) begin : g_side
      // each side owns all of its state below
      tlc_pkg::tlc_state_e state_reg;
      tlc_pkg::tlc_state_e state_next;
      logic [tlc_pkg::POS_W-1:0] pos_reg;
      logic [tlc_pkg::POS_W-1:0] pos_next;
      logic [1:0] rep_reg;
      logic [1:0] rep_next;
      logic [1:0] chg_reg;
      logic [1:0] chg_next;
      logic err_reg;
      logic err_next;
      logic lol_reg;
      logic lol_next;
      logic tim_reg;
      logic tim_next;
      logic rdi_reg;
      logic rdi_next;
      logic ais_reg;
      logic ais_next;
      tlc_pkg::tlc_msg_t acc_reg;
      tlc_pkg::tlc_msg_t acc_next;
      tlc_pkg::tlc_msg_t exp_reg;
      tlc_pkg::tlc_msg_t exp_next;

      tlc_pkg::tlc_trace_s tin;
      logic enabled;
      logic [3:0] acc_page;
      logic [3:0] exp_page;
      logic acc_wr;
      logic exp_wr;
      logic acc_sel;
      logic exp_sel;
      logic [tlc_pkg::POS_W-1:0] cpu_idx;
      logic is_start;
      logic fits;
      logic byte_diff;
      logic msg_err;
      logic exp_differs;

      assign tin = TRACE_IN[s];
      // 64-byte size or compare off keeps the machine parked
      assign enabled = TRACE_MODE[s].compare_enable &
                       ~TRACE_MODE[s].length_select;

      assign acc_page = (s == 0) ? tlc_pkg::ACC_A_BASE[7:4]
                                 : tlc_pkg::ACC_B_BASE[7:4];
      assign exp_page = (s == 0) ? tlc_pkg::EXP_A_BASE[7:4]
                                 : tlc_pkg::EXP_B_BASE[7:4];
      assign cpu_idx = CPU_ADDR[3:0];
      // whole-page decode; the low nibble picks the byte
      assign acc_sel = (CPU_ADDR[7:4] == acc_page);
      assign exp_sel = (CPU_ADDR[7:4] == exp_page);
      assign acc_wr = CPU_WR & acc_sel;
      assign exp_wr = CPU_WR & exp_sel;

      // framing test on the live byte at the expected position
      tlc_align_chk u_align (
        .data(tin.data),
        .pos(pos_reg),
        .is_start(is_start),
        .fits(fits)
      );

      // accepted against expected, all sixteen bytes at once
      tlc_msg_cmp #(
        .BYTES(tlc_pkg::MSG_BYTES)
      ) u_cmp (
        .left_msg(acc_reg),
        .right_msg(exp_reg),
        .differ(exp_differs)
      );

      // incoming byte against the accepted copy at the same position
      assign byte_diff = (tin.data != acc_reg[pos_reg]);
      // an error earlier in this message counts as well
      assign msg_err = err_reg | byte_diff;

      // per-side read answer; zero when neither page is ours
      assign side_hit[s] = acc_sel | exp_sel;
      assign side_rdata[s] = acc_sel ? acc_reg[cpu_idx] :
                             exp_sel ? exp_reg[cpu_idx] :
                             tlc_pkg::BYTE_RESET;

      // one next-state block for the machine and both stores
      always_comb begin
        state_next = state_reg;
        pos_next = pos_reg;
        rep_next = rep_reg;
        chg_next = chg_reg;
        err_next = err_reg;
        lol_next = lol_reg;
        tim_next = tim_reg;
        acc_next = acc_reg;
        exp_next = exp_reg;

        if (!enabled) begin
          // parking clears the counters so a re-enable starts clean
          state_next = tlc_pkg::ST_IDLE;
          pos_next = tlc_pkg::POS_FIRST;
          rep_next = tlc_pkg::CNT_ZERO;
          chg_next = tlc_pkg::CNT_ZERO;
          err_next = 1'b0;
          lol_next = 1'b0;
          tim_next = 1'b0;
        end else begin
          unique case (state_reg)
            tlc_pkg::ST_IDLE: begin
              // start of sequence: alarms initialised at once
              state_next = tlc_pkg::ST_SEARCH;
              pos_next = tlc_pkg::POS_FIRST;
              rep_next = tlc_pkg::CNT_ZERO;
              chg_next = tlc_pkg::CNT_ZERO;
              lol_next = 1'b1;
              tim_next = 1'b0;
            end
            tlc_pkg::ST_SEARCH: begin
              if (tin.valid) begin
                if (is_start) begin
                  // a new one-bit restarts capture at byte 0
                  acc_next[tlc_pkg::POS_FIRST] = tin.data;
                  pos_next = tlc_pkg::POS_NEXT;
                end else if (fits) begin
                  // zero-msb bytes at position 0 never reach here
                  acc_next[pos_reg] = tin.data;
                  pos_next = pos_reg + tlc_pkg::POS_NEXT;
                  if (pos_reg == tlc_pkg::POS_LAST) begin
                    state_next = tlc_pkg::ST_REPEAT;
                    rep_next = tlc_pkg::CNT_ZERO;
                  end
                end
              end
            end
            tlc_pkg::ST_REPEAT: begin
              if (tin.valid) begin
                if (byte_diff) begin
                  // no waiting for message end: any error abandons
                  state_next = tlc_pkg::ST_SEARCH;
                  pos_next = tlc_pkg::POS_FIRST;
                  rep_next = tlc_pkg::CNT_ZERO;
                end else begin
                  pos_next = pos_reg + tlc_pkg::POS_NEXT;
                  if (pos_reg == tlc_pkg::POS_LAST) begin
                    rep_next = rep_reg + tlc_pkg::CNT_ONE;
                    if (rep_reg + tlc_pkg::CNT_ONE ==
                        tlc_pkg::REPEATS_TO_LOCK) begin
                      state_next = tlc_pkg::ST_LOCKED;
                      lol_next = 1'b0;
                      tim_next = 1'b0;
                      chg_next = tlc_pkg::CNT_ZERO;
                      err_next = 1'b0;
                    end
                  end
                end
              end
            end
            tlc_pkg::ST_LOCKED: begin
              // sticky: expected rewrites cannot clear it
              tim_next = tim_reg | exp_differs;
              if (tin.valid) begin
                err_next = msg_err;
                pos_next = pos_reg + tlc_pkg::POS_NEXT;
                if (pos_reg == tlc_pkg::POS_LAST) begin
                  // one verdict per message, taken at its last byte
                  err_next = 1'b0;
                  if (msg_err) begin
                    chg_next = chg_reg + tlc_pkg::CNT_ONE;
                    if (chg_reg + tlc_pkg::CNT_ONE ==
                        tlc_pkg::CHANGES_TO_UNLOCK) begin
                      // straight back to search, alarms as at start
                      state_next = tlc_pkg::ST_SEARCH;
                      pos_next = tlc_pkg::POS_FIRST;
                      lol_next = 1'b1;
                      tim_next = 1'b0;
                      rep_next = tlc_pkg::CNT_ZERO;
                      chg_next = tlc_pkg::CNT_ZERO;
                    end
                  end else begin
                    // only consecutive changed messages count
                    chg_next = tlc_pkg::CNT_ZERO;
                  end
                end
              end
            end
          endcase
        end

        // software writes win over a same-cycle capture
        if (acc_wr) begin
          acc_next[cpu_idx] = CPU_WDATA;
        end
        if (exp_wr) begin
          exp_next[cpu_idx] = CPU_WDATA;
        end
      end

      always_comb begin
        rdi_next = tim_reg & CONSEQ_ENABLE[s].rdi_enable;
        ais_next = tim_reg & CONSEQ_ENABLE[s].ais_enable;
      end

      // consequent actions lag the mismatch flag by one clock
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          rdi_reg <= 1'b0;
          ais_reg <= 1'b0;
        end else begin
          rdi_reg <= rdi_next;
          ais_reg <= ais_next;
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          state_reg <= tlc_pkg::ST_IDLE;
          pos_reg <= tlc_pkg::POS_FIRST;
          rep_reg <= tlc_pkg::CNT_ZERO;
          chg_reg <= tlc_pkg::CNT_ZERO;
          err_reg <= 1'b0;
          lol_reg <= 1'b0;
          tim_reg <= 1'b0;
          acc_reg <= '0;
          exp_reg <= '0;
        end else begin
          state_reg <= state_next;
          pos_reg <= pos_next;
          rep_reg <= rep_next;
          chg_reg <= chg_next;
          err_reg <= err_next;
          lol_reg <= lol_next;
          tim_reg <= tim_next;
          acc_reg <= acc_next;
          exp_reg <= exp_next;
        end
      end

      assign ALARM_OUT[s].lock_lost = lol_reg;
      assign ALARM_OUT[s].mismatch = tim_reg;
      assign ALARM_OUT[s].send_rdi = rdi_reg;
      assign ALARM_OUT[s].send_ais = ais_reg;
    end
  endgenerate

  // with two sides the pages never overlap, so an or of the side answers is safe
  always_comb begin
    rd_or = tlc_pkg::BYTE_RESET;
    for (int i = 0; i < SIDES; i++) begin
      rd_or = rd_or | side_rdata[i];
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (CPU_RD) begin
      // unmapped addresses read back as zero
      rdata_next = (|side_hit) ? rd_or : tlc_pkg::BYTE_RESET;
    end
  end

  // registered so the bus sees a byte that cannot glitch
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_reg <= tlc_pkg::BYTE_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign CPU_RDATA = rdata_reg;

endmodule : tlc_top

// ---- tb/tlc_assertions.sv ----
/*
  Checker on the top ports: side A alarms and the register port.
  Assumes it is bound into tlc_top.
*/
`timescale 1ns/100ps
module tlc_assertions #(
  parameter int SIDES = 2
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire tlc_pkg::tlc_trace_s [SIDES-1:0] TRACE_IN,
  input wire tlc_pkg::tlc_mode_s [SIDES-1:0] TRACE_MODE,
  input wire tlc_pkg::tlc_conseq_s [SIDES-1:0] CONSEQ_ENABLE,
  input wire logic [7:0] CPU_ADDR,
  input wire logic CPU_RD,
  input wire logic [7:0] CPU_RDATA,
  input wire tlc_pkg::tlc_alarm_s [SIDES-1:0] ALARM_OUT
);
  logic run;
  tlc_pkg::tlc_alarm_s al;
  assign run = TRACE_MODE[0].compare_enable && !TRACE_MODE[0].length_select;
  assign al = ALARM_OUT[0];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_enable_sets_lost: assert property (
    $rose(run) ##1 run |-> al.lock_lost && !al.mismatch)
    else $error("enable did not start search");
  a_disabled_quiet: assert property (
    !run |=> !al.lock_lost && !al.mismatch)
    else $error("alarm while disabled");
  a_rdi_follows: assert property (
    al.mismatch && CONSEQ_ENABLE[0].rdi_enable |=> al.send_rdi)
    else $error("rdi not sent");
  a_alarm_exclusive: assert property (
    al.mismatch |-> !al.lock_lost)
    else $error("mismatch without lock");
  a_lock_on_byte: assert property (
    $fell(al.lock_lost) && $past(run) |-> $past(TRACE_IN[0].valid))
    else $error("lock without a byte");
  a_mismatch_locked: assert property (
    $rose(al.mismatch) |-> !$past(al.lock_lost))
    else $error("mismatch before lock");
  a_clear_on_loss: assert property (
    $fell(al.mismatch) && $past(run) |-> al.lock_lost)
    else $error("mismatch cleared while locked");
  a_unmapped_zero: assert property (
    CPU_RD && CPU_ADDR[6:5] != 2'b10 |=> CPU_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule : tlc_assertions

bind tlc_top tlc_assertions #(.SIDES(SIDES)) chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .TRACE_IN(TRACE_IN),
  .TRACE_MODE(TRACE_MODE), .CONSEQ_ENABLE(CONSEQ_ENABLE),
  .CPU_ADDR(CPU_ADDR), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA),
  .ALARM_OUT(ALARM_OUT));

// ---- tb/tlc_mapper_model.sv ----
/*
  Upstream mapper model: repeats a 16-byte trace message on one drop side.
  Assumes run and slow change off the rising edge.
*/
`timescale 1ns/100ps
module tlc_mapper_model (
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  input wire tlc_pkg::tlc_msg_t msg,
  output tlc_pkg::tlc_trace_s trace
);
  int idx;
  logic gap;
  logic go;
  tlc_pkg::tlc_trace_s nxt;
  initial begin
    trace = '0;
    nxt = '0;
    idx = 0;
    gap = 1'b0;
    go = 1'b0;
    forever begin
      // inputs read on the rising edge, bus changed on the falling one
      @(posedge clk);
      go = run && !gap;
      nxt.valid = go;
      if (go) begin
        nxt.data = {idx == 0, msg[idx][6:0]};
        idx = (idx + 1) % 16;
      end else begin
        // idle bus toggles, never parks on the last byte
        nxt.data = ~trace.data;
        if (!run) idx = 0;
      end
      gap = slow && !gap;
      @(negedge clk);
      trace = nxt;
    end
  end
endmodule : tlc_mapper_model

// ---- tb/tlc_top_test.sv ----
/*
  Self-checking bench for the trace lock and compare block, both sides.
  Assumes the mapper model and the bound checker.
*/
`timescale 1ns/100ps
module tlc_top_test;
  logic clk_sys, reset, cpu_wr, cpu_rd, slow;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, rd_val;
  tlc_pkg::tlc_trace_s tr_a, tr_b;
  tlc_pkg::tlc_mode_s [1:0] mode;
  tlc_pkg::tlc_conseq_s [1:0] conseq;
  tlc_pkg::tlc_alarm_s [1:0] alarm;
  tlc_pkg::tlc_msg_t msg_a, msg_b;
  logic [1:0] run;
  int fail_count, n_tests, waited;

  tlc_top dut (.CLK_SYS(clk_sys), .RESET(reset), .TRACE_IN({tr_b, tr_a}),
    .TRACE_MODE(mode), .CONSEQ_ENABLE(conseq), .CPU_ADDR(cpu_addr),
    .CPU_WR(cpu_wr), .CPU_RD(cpu_rd), .CPU_WDATA(cpu_wdata),
    .CPU_RDATA(cpu_rdata), .ALARM_OUT(alarm));
  tlc_mapper_model far_a (.clk(clk_sys), .run(run[0]), .slow(slow),
    .msg(msg_a), .trace(tr_a));
  tlc_mapper_model far_b (.clk(clk_sys), .run(run[1]), .slow(slow),
    .msg(msg_b), .trace(tr_b));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic results;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk_sys);
    cpu_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    rd_val = cpu_rdata;
  endtask : rd

  task automatic load(input logic [7:0] base, input tlc_pkg::tlc_msg_t m);
    for (int k = 0; k < 16; k++) wr(base + 8'(k), m[k]);
  endtask : load

  // lock_lost of one side reaching a level, bounded
  task automatic wt(input int s, input logic v, input int lim);
    waited = 0;
    while (alarm[s].lock_lost !== v && waited < lim) begin
      @(negedge clk_sys);
      waited++;
    end
    ck({7'h0, alarm[s].lock_lost}, {7'h0, v});
  endtask : wt

  function automatic tlc_pkg::tlc_msg_t mk(input logic [6:0] seed);
    tlc_pkg::tlc_msg_t m;
    for (int k = 0; k < 16; k++) m[k] = {k == 0, seed + 7'(k)};
    return m;
  endfunction : mk

  task automatic t_regs;
    rd(8'h4F);
    ck(rd_val, 8'h00);
    wr(8'h5F, 8'h3C);
    wr(8'hC3, 8'h55);
    rd(8'h5F);
    ck(rd_val, 8'h3C);
    rd(8'hC3);
    ck(rd_val, 8'h55);
    wr(8'h2A, 8'hAA);
    rd(8'h2A);
    ck(rd_val, 8'h00);
  endtask : t_regs

  task automatic t_lock;
    msg_a = mk(7'h20);
    msg_b = mk(7'h30);
    load(8'h50, msg_a);
    load(8'hD0, mk(7'h31));
    mode = 4'b1010;
    conseq = 4'b1111;
    repeat (2) @(negedge clk_sys);
    ck({4'h0, alarm[0]}, 8'h08);
    run = 2'b11;
    wt(0, 1'b0, 200);
    ck({7'h0, waited > 60}, 8'h01);
    repeat (3) @(negedge clk_sys);
    ck({4'h0, alarm[0]}, 8'h00);
    ck({4'h0, alarm[1]}, 8'h07);
    rd(8'h45);
    ck(rd_val, msg_a[5]);
    rd(8'hC0);
    ck(rd_val, msg_b[0]);
  endtask : t_lock

  task automatic t_change;
    slow = 1'b1;
    msg_a = mk(7'h50);
    wt(0, 1'b1, 300);
    ck({7'h0, waited > 64}, 8'h01);
    wt(0, 1'b0, 400);
    ck({7'h0, waited > 120}, 8'h01);
    rd(8'h49);
    ck(rd_val, msg_a[9]);
    ck({4'h0, alarm[0]}, 8'h07);
  endtask : t_change

  task automatic t_sticky;
    load(8'h50, msg_a);
    ck({4'h0, alarm[0]}, 8'h07);
    conseq = 4'hE;
    repeat (2) @(negedge clk_sys);
    ck({4'h0, alarm[0]}, 8'h06);
    conseq = 4'hF;
    wr(8'h40, 8'h00);
    wt(0, 1'b1, 200);
    @(negedge clk_sys);
    ck({4'h0, alarm[0]}, 8'h08);
    wt(0, 1'b0, 400);
    ck({7'h0, waited > 120}, 8'h01);
    repeat (3) @(negedge clk_sys);
    ck({4'h0, alarm[0]}, 8'h00);
  endtask : t_sticky

  task automatic t_off;
    mode = 4'b1110;
    repeat (2) @(negedge clk_sys);
    ck({4'h0, alarm[1]}, 8'h00);
    ck({4'h0, alarm[0]}, 8'h00);
    mode = 4'b1010;
    repeat (2) @(negedge clk_sys);
    ck({4'h0, alarm[1]}, 8'h08);
    mode = 4'b0010;
    repeat (2) @(negedge clk_sys);
    ck({4'h0, alarm[1]}, 8'h00);
  endtask : t_off

  // mid-run reset: stores, read data and alarms back to zero
  task automatic t_reset;
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (3) @(negedge clk_sys);
    ck(cpu_rdata, 8'h00);
    ck({4'h0, alarm[0]}, 8'h00);
    reset = 1'b0;
    rd(8'h5F);
    ck(rd_val, 8'h00);
    rd(8'h4F);
    ck(rd_val, 8'h00);
    ck({4'h0, alarm[0]}, 8'h08);
  endtask : t_reset

  initial begin
    fail_count = 0;
    n_tests = 0;
    reset = 1'b1;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    mode = '0;
    conseq = '0;
    run = 2'b00;
    slow = 1'b0;
    msg_a = '0;
    msg_b = '0;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    t_regs;
    t_lock;
    t_change;
    t_sticky;
    t_off;
    t_reset;
    results;
  end

  initial begin
    // tests need about 700 cycles; margin for slow relocks
    repeat (6000) @(posedge clk_sys);
    fail_count++;
    results;
  end
endmodule : tlc_top_test
